// ---- design/mqs_pkg.sv ----
package mqs_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [7:0] MQS_OFF_CTRL = 8'h00;   // Mode and control flags
	localparam logic [7:0] MQS_OFF_FPU = 8'h04;    // Stack top and tag word
	localparam logic [7:0] MQS_OFF_FAULT = 8'h08;  // Last fault record
	localparam logic [7:0] MQS_OFF_COUNT = 8'h0c;  // Stores issued

	// ----------------------------------------------------------------
	// Control register fields
	// ----------------------------------------------------------------
	localparam int MQS_CTRL_MODE_LSB = 0;   // Three bits of operating mode
	localparam int MQS_CTRL_ASIZE_LSB = 3;  // Two bits of address size
	localparam int MQS_CTRL_TS_BIT = 5;     // Task switched flag
	localparam int MQS_CTRL_EM_BIT = 6;     // Emulation flag
	localparam int MQS_CTRL_OSFX_BIT = 7;   // OS extended save support flag
	localparam int MQS_CTRL_SIMD_BIT = 8;   // SIMD extension feature flag
	localparam int MQS_CTRL_AC_BIT = 9;     // Alignment checking enabled
	localparam int MQS_CTRL_CPL_LSB = 10;   // Two bits of privilege level
	localparam logic [31:0] MQS_CTRL_RST = 32'h0000_0180;

	// ----------------------------------------------------------------
	// Stack state register fields
	// ----------------------------------------------------------------
	localparam int MQS_FPU_TOP_LSB = 0;     // Three bits of stack top
	localparam int MQS_FPU_TAG_LSB = 3;     // Sixteen bits of tag word
	localparam logic [2:0] MQS_TOP_RST = 3'h0;
	localparam logic [15:0] MQS_TAG_RST = 16'hffff;
	localparam logic [2:0] MQS_TOP_MMX = 3'h0;
	localparam logic [15:0] MQS_TAG_VALID = 16'h0000;

	// ----------------------------------------------------------------
	// Limits and fault vectors
	// ----------------------------------------------------------------
	localparam logic [63:0] MQS_REAL_LIMIT = 64'h0000_0000_0000_ffff;
	localparam logic [63:0] MQS_OPND_LAST = 64'h0000_0000_0000_0007;
	localparam logic [1:0] MQS_MOD_REG = 2'h3;
	localparam logic [1:0] MQS_CPL_USER = 2'h3;
	localparam logic [7:0] MQS_VEC_UD = 8'h06;
	localparam logic [7:0] MQS_VEC_NM = 8'h07;
	localparam logic [7:0] MQS_VEC_SS = 8'h0c;
	localparam logic [7:0] MQS_VEC_GP = 8'h0d;
	localparam logic [7:0] MQS_VEC_PF = 8'h0e;
	localparam logic [7:0] MQS_VEC_MF = 8'h10;
	localparam logic [7:0] MQS_VEC_AC = 8'h11;

	// Operating modes
	typedef enum logic [2:0] {
		MQS_REAL = 3'h0,
		MQS_V86 = 3'h1,
		MQS_PROT = 3'h2,
		MQS_COMPAT = 3'h3,
		MQS_LONG = 3'h4
	} mqs_mode_t;

	// Address size attribute
	localparam logic [1:0] MQS_AS16 = 2'h0;
	localparam logic [1:0] MQS_AS32 = 2'h1;

	// Sequencer states
	typedef enum logic [3:0] {
		MQS_IDLE = 4'b0001,
		MQS_CHECK = 4'b0010,
		MQS_STORE = 4'b0100,
		MQS_DONE = 4'b1000
	} mqs_state_t;

endpackage : mqs_pkg

// ---- design/mqs_lane.sv ----
`timescale 1ns/10ps
// ------------------------------------------------------------------
// One byte lane: top bit of the mask byte gives the lane enable for the source byte
// ------------------------------------------------------------------
module mqs_lane
	import mqs_pkg::*;
(
	input wire logic [7:0] src_byte,
	input wire logic [7:0] mask_byte,
	output logic lane_en,
	output logic [7:0] lane_data
);

	// lane enable from mask top bit
	assign lane_en = mask_byte[7];
	// Data passes whole; the byte enable decides if it lands
	assign lane_data = src_byte;

endmodule : mqs_lane

// ---- design/mqs_fault_chk.sv ----
`timescale 1ns/10ps
// ------------------------------------------------------------------
// Address forming and fault checks, purely combinational
// ------------------------------------------------------------------
module mqs_fault_chk
	import mqs_pkg::*;
(
	input wire logic [31:0] ctrl,
	input wire logic [1:0] mod_field,
	input wire logic lock_pfx,
	input wire logic fpu_pend,
	input wire logic [63:0] dst_index,
	input wire logic [63:0] seg_base,
	input wire logic [31:0] seg_limit,
	input wire logic seg_null,
	input wire logic seg_wr,
	input wire logic seg_ss,
	output logic fault,
	output logic [7:0] vector,
	output logic [63:0] lin_addr
);

	mqs_mode_t mode;
	logic [1:0] asize;
	logic [63:0] offs;      // Effective offset at address size
	logic [63:0] last;      // Offset of the last operand byte
	logic ud;
	logic canon_ok;
	logic seg_bad;
	logic lim_bad;
	logic ac;

	always_comb begin
		mode = mqs_mode_t'(ctrl[MQS_CTRL_MODE_LSB +: 3]);
		asize = ctrl[MQS_CTRL_ASIZE_LSB +: 2];
		if (asize == MQS_AS16) begin
			offs = {48'h0, dst_index[15:0]};
		end else if (asize == MQS_AS32) begin
			offs = {32'h0, dst_index[31:0]};
		end else begin
			offs = dst_index;
		end
		last = offs + MQS_OPND_LAST;
		// full wide index in 64-bit mode
		if (mode == MQS_LONG) begin
			lin_addr = seg_base + dst_index;
		end else begin
			lin_addr = {32'h0, seg_base[31:0] + offs[31:0]};
		end
		ud = ctrl[MQS_CTRL_EM_BIT] | ~ctrl[MQS_CTRL_SIMD_BIT] | lock_pfx;
		if (mode == MQS_PROT || mode == MQS_COMPAT || mode == MQS_LONG) begin
			ud = ud | (mod_field != MQS_MOD_REG);
		end
		// extended save support off is invalid in real, virtual-8086 and 64-bit modes
		if (mode == MQS_REAL || mode == MQS_V86 || mode == MQS_LONG) begin
			ud = ud | ~ctrl[MQS_CTRL_OSFX_BIT];
		end
		canon_ok = (lin_addr[63:47] == {17{lin_addr[47]}});
		// Segment checks never look at the mask, so zero masks fault too
		seg_bad = 1'b0;
		lim_bad = 1'b0;
		case (mode)
			// real mode range 0 to ffff
			MQS_REAL, MQS_V86: begin
				seg_bad = (last > MQS_REAL_LIMIT);
			end
			MQS_PROT, MQS_COMPAT: begin
				lim_bad = (last > {32'h0, seg_limit});
				seg_bad = lim_bad | ~seg_wr | (seg_null & ~seg_ss);
			end
			MQS_LONG: begin
				lim_bad = ~canon_ok;
				seg_bad = lim_bad;
			end
			default: begin
				seg_bad = 1'b0;
			end
		endcase
		ac = ctrl[MQS_CTRL_AC_BIT] & (lin_addr[2:0] != 3'h0)
			& (ctrl[MQS_CTRL_CPL_LSB +: 2] == MQS_CPL_USER) & (mode != MQS_REAL);
		if (mode == MQS_V86) begin
			ac = ctrl[MQS_CTRL_AC_BIT] & (lin_addr[2:0] != 3'h0);
		end
		// Priority: opcode, device, pending error, segment, alignment
		fault = 1'b1;
		if (ud) begin
			vector = MQS_VEC_UD;
		end else if (ctrl[MQS_CTRL_TS_BIT]) begin
			vector = MQS_VEC_NM;
		end else if (fpu_pend) begin
			vector = MQS_VEC_MF;
		end else if (lim_bad && seg_ss && mode != MQS_REAL && mode != MQS_V86) begin
			vector = MQS_VEC_SS;
		end else if (seg_bad) begin
			vector = MQS_VEC_GP;
		end else if (ac) begin
			vector = MQS_VEC_AC;
		end else begin
			fault = 1'b0;
			vector = 8'h00;
		end
	end

endmodule : mqs_fault_chk

// ---- design/mqs_store.sv ----
`timescale 1ns/10ps
// Overview of operation
// - Store mask-selected bytes of 64-bit source
// - Mask byte top bit enables each lane
// - Legacy address: data segment plus index
// - 64-bit mode uses full wide index
// - Lane k lands at base plus k
// - Store carries non-temporal write-combining hint
// - Set stack top zero, tags valid
// - Zero mask: no write, state still moves
// - Zero mask skips breakpoints and type semantics
// - No read for ownership of line
// - Protected general protection segment faults
// - Protected stack fault on illegal address
// - Task switched flag gives device fault
// - Pending floating error faults after opcode and device checks
// - Invalid opcode: emulation, feature, mod, lock
// - Real mode range and save flag
// - Alignment fault outside real mode at privilege three, at any privilege in virtual-8086
// - Virtual-8086 uses real checks plus more
// - Page fault may come from memory
// - 64-bit non-canonical address faults
// - Source from reg, mask from r/m
module mqs_store
	import mqs_pkg::*;
(
	input wire logic clk,
	input wire logic srst,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// Instruction pipeline side
	input wire logic op_valid,
	output logic op_ready,
	input wire logic [63:0] op_src,
	input wire logic [63:0] op_mask,
	input wire logic [1:0] op_mod,
	input wire logic op_lock,
	input wire logic op_fpu_pend,
	input wire logic [63:0] op_dst_index,
	input wire logic [63:0] op_seg_base,
	input wire logic [31:0] op_seg_limit,
	input wire logic op_seg_null,
	input wire logic op_seg_wr,
	input wire logic op_seg_ss,
	// Results to the pipeline
	output logic done_valid,
	output logic fault_valid,
	output logic [7:0] fault_vector,
	output logic [31:0] fault_code,
	// Stack state
	output logic [2:0] fpu_top,
	output logic [15:0] fpu_tag,
	// Memory subsystem side
	output logic mem_req,
	output logic [63:0] mem_addr,
	output logic [63:0] mem_wdata,
	output logic [7:0] mem_be,
	output logic mem_wc_hint,
	output logic mem_no_rfo,
	input wire logic mem_ack,
	input wire logic mem_pf,
	input wire logic [31:0] mem_pf_code
);

	// ----------------------------------------------------------------
	// State record
	// ----------------------------------------------------------------
	typedef struct packed {
		mqs_state_t st;          // Sequencer state
		logic [31:0] ctrl;       // Mode and control flags
		logic [2:0] top;         // Stack top pointer
		logic [15:0] tag;        // Tag word
		// Captured operands
		logic [63:0] src;        // Captured source operand
		logic [63:0] mask;       // Captured mask operand
		logic [1:0] mod;         // Captured mod field
		logic lock;              // Lock prefix seen
		logic pend;              // Floating error pending
		logic [63:0] didx;       // Destination index
		logic [63:0] base;       // Data segment base
		logic [31:0] limit;      // Data segment limit
		logic snull;             // Null selector
		logic swr;               // Segment writable
		logic sss;               // Reference through stack segment
		// Pipeline results
		logic ready;             // Pipeline may issue
		logic done;              // Completion pulse
		logic fault;             // Fault pulse
		logic [7:0] vec;         // Fault vector
		logic [31:0] code;       // Fault error code
		// Memory request
		logic req;               // Store request level
		logic [63:0] addr;       // Store address
		logic [63:0] wdata;      // Store data
		logic [7:0] be;          // Store byte enables
		// Register side
		logic [31:0] rdata;      // Register read data
		logic [31:0] flog;       // Last fault record
		logic [31:0] count;      // Stores issued
	} mqs_regs_t;

	mqs_regs_t r_reg;
	mqs_regs_t r_next;

	// Checker results, valid while in the check state
	logic chk_fault;
	logic [7:0] chk_vec;
	logic [63:0] chk_addr;
	// Lane outputs
	logic [7:0] lane_en;
	logic [63:0] lane_data;

	// ----------------------------------------------------------------
	// Byte lanes
	// ----------------------------------------------------------------
	// Eight identical lanes
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_lane
			mqs_lane u_lane (
				.src_byte(r_reg.src[8*gi +: 8]),
				.mask_byte(r_reg.mask[8*gi +: 8]),
				.lane_en(lane_en[gi]),
				.lane_data(lane_data[8*gi +: 8])
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// Fault checker
	// ----------------------------------------------------------------
	// Reads the captured copies only
	mqs_fault_chk u_chk (
		.ctrl(r_reg.ctrl),
		.mod_field(r_reg.mod),
		.lock_pfx(r_reg.lock),
		.fpu_pend(r_reg.pend),
		.dst_index(r_reg.didx),
		.seg_base(r_reg.base),
		.seg_limit(r_reg.limit),
		.seg_null(r_reg.snull),
		.seg_wr(r_reg.swr),
		.seg_ss(r_reg.sss),
		.fault(chk_fault),
		.vector(chk_vec),
		.lin_addr(chk_addr)
	);

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		r_next = r_reg;

		// Pulses last one cycle
		r_next.done = 1'b0;
		r_next.fault = 1'b0;
		r_next.rdata = 32'h0;

		// Software writes come first so that hardware updates win
		if (reg_wr) begin
			case (reg_addr)
				MQS_OFF_CTRL: begin
					r_next.ctrl = reg_wdata;
				end
				MQS_OFF_FPU: begin
					r_next.top = reg_wdata[MQS_FPU_TOP_LSB +: 3];
					r_next.tag = reg_wdata[MQS_FPU_TAG_LSB +: 16];
				end
				MQS_OFF_FAULT: begin
					r_next.flog = 32'h0;
				end
				MQS_OFF_COUNT: begin
					r_next.count = 32'h0;
				end
				default: begin
					// Unmapped writes are dropped
				end
			endcase
		end

		// Read data stand in the cycle after the strobe
		if (reg_rd) begin
			case (reg_addr)
				MQS_OFF_CTRL: begin
					r_next.rdata = r_reg.ctrl;
				end
				MQS_OFF_FPU: begin
					r_next.rdata = {13'h0, r_reg.tag, r_reg.top};
				end
				MQS_OFF_FAULT: begin
					r_next.rdata = r_reg.flog;
				end
				MQS_OFF_COUNT: begin
					r_next.rdata = r_reg.count;
				end
				default: begin
					// Unmapped reads return zero
					r_next.rdata = 32'h0;
				end
			endcase
		end

		case (r_reg.st)
			// Wait for an instruction from the pipeline
			MQS_IDLE: begin
				// Operands held still for the checks
				if (op_valid) begin
					r_next.src = op_src;
					r_next.mask = op_mask;
					r_next.mod = op_mod;
					r_next.lock = op_lock;
					r_next.pend = op_fpu_pend;
					r_next.didx = op_dst_index;
					r_next.base = op_seg_base;
					r_next.limit = op_seg_limit;
					r_next.snull = op_seg_null;
					r_next.swr = op_seg_wr;
					r_next.sss = op_seg_ss;

					r_next.ready = 1'b0;
					r_next.st = MQS_CHECK;
				end
			end

			// Checks settle on captured operands
			MQS_CHECK: begin
				if (chk_fault) begin
					// Checker fault leaves stack state alone
					r_next.fault = 1'b1;
					r_next.vec = chk_vec;
					r_next.code = 32'h0;
					r_next.flog = {24'h0, chk_vec};

					r_next.st = MQS_DONE;
				end else begin
					r_next.top = MQS_TOP_MMX;
					r_next.tag = MQS_TAG_VALID;

					// so no breakpoint or type action
					if (lane_en == 8'h00) begin
						r_next.done = 1'b1;
						r_next.st = MQS_DONE;
					end else begin
						r_next.req = 1'b1;
						// lane k at base plus k
						r_next.addr = chk_addr;
						r_next.wdata = lane_data;
						r_next.be = lane_en;
						r_next.st = MQS_STORE;
					end
				end
			end

			// Hold the request until memory takes it
			MQS_STORE: begin
				if (mem_ack) begin
					r_next.req = 1'b0;
					// Counted even on a page fault
					r_next.count = r_next.count + 32'h1;

					// memory may answer with a page fault
					if (mem_pf) begin
						r_next.fault = 1'b1;
						r_next.vec = MQS_VEC_PF;
						r_next.code = mem_pf_code;
						r_next.flog = {24'h0, MQS_VEC_PF};
					end else begin
						r_next.done = 1'b1;
					end
					r_next.st = MQS_DONE;
				end
			end

			// One cycle of rest before the next issue
			MQS_DONE: begin
				r_next.ready = 1'b1;
				r_next.st = MQS_IDLE;
			end

			default: begin
				// Unknown code: drop request, go idle
				r_next.req = 1'b0;
				r_next.ready = 1'b1;
				r_next.st = MQS_IDLE;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (srst) begin
			// Clear all, then the non-zero resets
			r_reg <= '0;
			r_reg.st <= MQS_IDLE;
			r_reg.ctrl <= MQS_CTRL_RST;
			r_reg.top <= MQS_TOP_RST;
			r_reg.tag <= MQS_TAG_RST;
			r_reg.ready <= 1'b1;
		end else begin
			r_reg <= r_next;
		end
	end

	// ----------------------------------------------------------------
	// Outputs, all from the state record
	// ----------------------------------------------------------------
	// Register port
	assign reg_rdata = r_reg.rdata;

	// Pipeline side
	assign op_ready = r_reg.ready;
	assign done_valid = r_reg.done;
	assign fault_valid = r_reg.fault;
	assign fault_vector = r_reg.vec;
	assign fault_code = r_reg.code;
	// Stack state
	assign fpu_top = r_reg.top;
	assign fpu_tag = r_reg.tag;

	// Memory side
	assign mem_req = r_reg.req;
	assign mem_addr = r_reg.addr;
	assign mem_wdata = r_reg.wdata;
	assign mem_be = r_reg.be;
	assign mem_wc_hint = r_reg.req;
	// no ownership read of the line
	assign mem_no_rfo = r_reg.req;

endmodule : mqs_store

// ---- verif/mqs_mem_model.sv ----
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Memory side: accepts one request after a chosen wait
// ----------------------------------------------------------------
module mqs_mem_model (
	input wire logic clk,
	input wire logic srst,
	input wire logic mem_req,
	output logic mem_ack,
	output logic mem_pf,
	output logic [31:0] mem_pf_code,
	input wire logic [1:0] ack_wait,
	input wire logic pf_on,
	input wire logic [31:0] pf_val
);
	logic [1:0] cnt_reg; // Cycles waited on this request

	// Fault lines toggle outside an acknowledge so stale values never look valid
	always @(posedge clk) begin
		mem_ack <= 1'h0;
		mem_pf <= ~mem_pf;
		mem_pf_code <= ~mem_pf_code;
		if (srst) begin
			cnt_reg <= 2'h0;
			mem_pf <= 1'h0;
			mem_pf_code <= 32'h0;
		end else if (mem_req && !mem_ack) begin
			// Guard on mem_ack stops a second accept of the same request
			if (cnt_reg >= ack_wait) begin
				mem_ack <= 1'h1;
				mem_pf <= pf_on;
				mem_pf_code <= pf_val;
				cnt_reg <= 2'h0;
			end else begin
				cnt_reg <= cnt_reg + 2'h1;
			end
		end
	end
endmodule : mqs_mem_model

// ---- verif/mqs_store_props.sv ----
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Port checker for the masked store block
// ----------------------------------------------------------------
module mqs_store_props
	import mqs_pkg::*;
(
	input wire logic clk,
	input wire logic srst,
	input wire logic op_valid,
	input wire logic op_ready,
	input wire logic op_lock,
	input wire logic done_valid,
	input wire logic fault_valid,
	input wire logic [7:0] fault_vector,
	input wire logic [31:0] fault_code,
	input wire logic [2:0] fpu_top,
	input wire logic [15:0] fpu_tag,
	input wire logic mem_req,
	input wire logic [63:0] mem_addr,
	input wire logic [63:0] mem_wdata,
	input wire logic [7:0] mem_be,
	input wire logic mem_wc_hint,
	input wire logic mem_no_rfo,
	input wire logic mem_ack,
	input wire logic mem_pf,
	input wire logic [31:0] mem_pf_code
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	// Steps of one instruction
	sequence s_take; op_valid && op_ready; endsequence
	sequence s_end; done_valid || fault_valid; endsequence
	sequence s_req; mem_req; endsequence
	sequence s_ack; mem_req && mem_ack; endsequence
	property p_answer; s_take |=> !op_ready ##1 (s_end or s_req); endproperty
	property p_hold; s_req ##0 !mem_ack |=>
		mem_req && $stable(mem_addr) && $stable(mem_wdata) && $stable(mem_be); endproperty
	property p_hint; mem_wc_hint == mem_req; endproperty
	property p_norfo; mem_no_rfo == mem_req; endproperty
	property p_zero; s_req |-> mem_be != 8'h00; endproperty
	property p_state; done_valid |-> fpu_top == MQS_TOP_MMX && fpu_tag == MQS_TAG_VALID; endproperty
	property p_pf; s_ack ##0 mem_pf |=>
		fault_valid && fault_vector == MQS_VEC_PF && fault_code == $past(mem_pf_code); endproperty
	property p_ok; s_ack ##0 !mem_pf |=> done_valid && !fault_valid && !mem_req; endproperty
	property p_lock; s_take ##0 op_lock |-> ##2 fault_valid && fault_vector == MQS_VEC_UD; endproperty
	property p_pulse; s_end |=> !done_valid && !fault_valid; endproperty
	a_answer: assert property (p_answer) else $error("no answer two cycles after take");
	a_hold: assert property (p_hold) else $error("request moved before accept");
	a_hint: assert property (p_hint) else $error("write combining hint wrong");
	a_norfo: assert property (p_norfo) else $error("ownership read not suppressed");
	a_zero: assert property (p_zero) else $error("request with empty byte enables");
	a_state: assert property (p_state) else $error("stack state not moved");
	a_pf: assert property (p_pf) else $error("page fault not passed on");
	a_ok: assert property (p_ok) else $error("store not completed");
	a_lock: assert property (p_lock) else $error("lock prefix not refused");
	a_pulse: assert property (p_pulse) else $error("completion pulse too long");
endmodule : mqs_store_props

bind mqs_store mqs_store_props props_u (.clk(clk), .srst(srst), .op_valid(op_valid),
	.op_ready(op_ready), .op_lock(op_lock), .done_valid(done_valid), .fault_valid(fault_valid),
	.fault_vector(fault_vector), .fault_code(fault_code), .fpu_top(fpu_top), .fpu_tag(fpu_tag),
	.mem_req(mem_req), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_be(mem_be),
	.mem_wc_hint(mem_wc_hint), .mem_no_rfo(mem_no_rfo), .mem_ack(mem_ack), .mem_pf(mem_pf),
	.mem_pf_code(mem_pf_code));

// ---- verif/byte_masked_quadword_store_tb_top.sv ----
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Random instruction bench with a reference model
// ----------------------------------------------------------------
module byte_masked_quadword_store_tb_top;
	import mqs_pkg::*;
	logic clk = 1'h0, srst = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0, op_valid = 1'h0;
	logic [7:0] reg_addr = 8'h0;
	logic [31:0] reg_wdata = 32'h0, reg_rdata, fault_code, op_seg_limit = 32'h0;
	logic op_ready, op_lock = 1'h0, op_fpu_pend = 1'h0, op_seg_null = 1'h0, op_seg_wr = 1'h1;
	logic op_seg_ss = 1'h0, done_valid, fault_valid, mem_req, mem_wc_hint, mem_no_rfo;
	logic [63:0] op_src = 64'h0, op_mask = 64'h0, op_dst_index = 64'h0, op_seg_base = 64'h0;
	logic [63:0] mem_addr, mem_wdata;
	logic [1:0] op_mod = 2'h3, ack_wait = 2'h0;
	logic [7:0] fault_vector, mem_be, lastv = 8'h0;
	logic [2:0] fpu_top;
	logic [15:0] fpu_tag;
	logic mem_ack, mem_pf, pf_on = 1'h0;
	logic [31:0] mem_pf_code, pf_val = 32'h0, ctl, fv, rd;
	int n_fail = 0, tests_run = 0, cyc = 0, n_st = 0;

	always #2.5 clk = ~clk;

	mqs_store dut_u (.clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .op_valid(op_valid),
		.op_ready(op_ready), .op_src(op_src), .op_mask(op_mask), .op_mod(op_mod),
		.op_lock(op_lock), .op_fpu_pend(op_fpu_pend), .op_dst_index(op_dst_index),
		.op_seg_base(op_seg_base), .op_seg_limit(op_seg_limit), .op_seg_null(op_seg_null),
		.op_seg_wr(op_seg_wr), .op_seg_ss(op_seg_ss), .done_valid(done_valid),
		.fault_valid(fault_valid), .fault_vector(fault_vector), .fault_code(fault_code),
		.fpu_top(fpu_top), .fpu_tag(fpu_tag), .mem_req(mem_req), .mem_addr(mem_addr),
		.mem_wdata(mem_wdata), .mem_be(mem_be), .mem_wc_hint(mem_wc_hint),
		.mem_no_rfo(mem_no_rfo), .mem_ack(mem_ack), .mem_pf(mem_pf), .mem_pf_code(mem_pf_code));

	mqs_mem_model mem_u (.clk(clk), .srst(srst), .mem_req(mem_req), .mem_ack(mem_ack),
		.mem_pf(mem_pf), .mem_pf_code(mem_pf_code), .ack_wait(ack_wait), .pf_on(pf_on),
		.pf_val(pf_val));

	// ----------------------------------------------------------------
	// Checking and closing
	// ----------------------------------------------------------------
	task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_fail++;
			$display("[FAIL] %s exp %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic test_done();
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : test_done

	// Ceiling well above 300 instructions of at most 14 cycles each
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			test_done();
		end
	end

	// ----------------------------------------------------------------
	// Register port cycles, one idle edge after each
	// ----------------------------------------------------------------
	task automatic reg_w(input logic [7:0] a, input logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'h1;
		@(posedge clk);
		reg_wr <= 1'h0;
		@(posedge clk);
	endtask : reg_w

	task automatic reg_r(input logic [7:0] a, output logic [31:0] d);
		reg_addr <= a;
		reg_rd <= 1'h1;
		@(posedge clk);
		reg_rd <= 1'h0;
		#1 d = reg_rdata;
		@(posedge clk);
	endtask : reg_r

	// ----------------------------------------------------------------
	// Reference fault model, priority UD, NM, MF, SS/GP, AC
	// ----------------------------------------------------------------
	function automatic logic [7:0] exp_vec(input logic [31:0] c, input logic [63:0] a,
		input logic [63:0] off);
		logic lng, prt, rl;
		lng = (c[2:0] == 3'h4);
		prt = (c[2:0] == 3'h2) || (c[2:0] == 3'h3);
		rl = (c[2:0] <= 3'h1);
		if (c[6] || !c[8] || op_lock || (!rl && op_mod != MQS_MOD_REG) || (!prt && !c[7]))
			return MQS_VEC_UD;
		if (c[5]) return MQS_VEC_NM;
		if (op_fpu_pend) return MQS_VEC_MF;
		if (prt && off + 64'h7 > {32'h0, op_seg_limit})
			return op_seg_ss ? MQS_VEC_SS : MQS_VEC_GP;
		if (prt && (!op_seg_wr || op_seg_null)) return MQS_VEC_GP;
		if (rl && off + 64'h7 > MQS_REAL_LIMIT) return MQS_VEC_GP;
		if (lng && a[63] != a[47]) return op_seg_ss ? MQS_VEC_SS : MQS_VEC_GP;
		if (c[9] && a[2:0] != 3'h0 && (c[2:0] == 3'h1 || (!rl && c[11:10] == MQS_CPL_USER)))
			return MQS_VEC_AC;
		return 8'h00;
	endfunction : exp_vec

	function automatic logic rare();
		return $urandom_range(0, 15) == 0;
	endfunction : rare

	// One instruction with random operands, checked against the model
	task automatic do_op();
		logic [63:0] off, a;
		logic [7:0] ev, be;
		logic seen, st;
		int n;
		ctl = {20'h0, 2'($urandom), 1'($urandom), !rare(), !rare(), rare(), rare(), 5'h0};
		ctl[2:0] = 3'($urandom_range(0, 4));
		ctl[4:3] = (ctl[2:0] == 3'h4) ? 2'h2 : 2'($urandom_range(0, 1));
		fv = 32'($urandom_range(1, 32'h7_ffff));
		reg_w(MQS_OFF_CTRL, ctl);
		reg_w(MQS_OFF_FPU, fv);
		op_src <= {$urandom, $urandom};
		op_mask <= rare() ? 64'h0 : {$urandom, $urandom};
		op_mod <= rare() ? 2'($urandom_range(0, 2)) : MQS_MOD_REG;
		op_lock <= rare();
		op_fpu_pend <= rare();
		st = (ctl[2:0] >= 3'h2) && rare();
		op_seg_ss <= st;
		op_seg_wr <= !rare();
		op_seg_null <= !st && rare();
		op_seg_limit <= rare() ? 32'($urandom_range(0, 32'hffff)) : 32'hffff_fff0;
		if (ctl[2:0] == 3'h4) begin
			op_seg_base <= 64'h0;
			op_dst_index <= rare() ? {8'h80, 24'h0, $urandom} : {32'h0, $urandom};
		end else begin
			op_seg_base <= {$urandom, $urandom};
			op_dst_index <= {$urandom, 15'h0, 17'($urandom_range(0, rare() ? 32'h1ffff : 32'hfff))};
		end
		pf_on <= rare();
		pf_val <= $urandom;
		ack_wait <= 2'($urandom);
		op_valid <= 1'h1;
		@(posedge clk);
		op_valid <= 1'h0;
		off = (ctl[4:3] == MQS_AS16) ? {48'h0, op_dst_index[15:0]} : {32'h0, op_dst_index[31:0]};
		a = (ctl[2:0] == 3'h4) ? op_seg_base + op_dst_index
			: {32'h0, op_seg_base[31:0] + off[31:0]};
		ev = exp_vec(ctl, a, off);
		for (int k = 0; k < 8; k++) be[k] = op_mask[8 * k + 7];
		seen = 1'h0;
		n = 0;
		do begin
			@(posedge clk);
			#1 n++;
			if (mem_req === 1'h1 && !seen) begin
				seen = 1'h1;
				chk("mem_addr", mem_addr, a);
				chk("mem_wdata", mem_wdata, op_src);
				chk("mem_be", mem_be, be);
				chk("hints", {mem_wc_hint, mem_no_rfo}, 2'h3);
			end
		end while (done_valid !== 1'h1 && fault_valid !== 1'h1 && n < 40);
		st = (ev == 8'h00) && (be != 8'h00);
		chk("mem_req", seen, st);
		chk("fault_valid", fault_valid, ev != 8'h00 || (st && pf_on));
		chk("done_valid", done_valid, ev == 8'h00 && !(st && pf_on));
		if (fault_valid === 1'h1) begin
			chk("fault_vector", fault_vector, (ev != 8'h00) ? ev : MQS_VEC_PF);
			chk("fault_code", fault_code, (ev != 8'h00) ? 32'h0 : pf_val);
			lastv = (ev != 8'h00) ? ev : MQS_VEC_PF;
		end
		n_st += st;
		@(posedge clk);
		reg_r(MQS_OFF_FPU, rd);
		chk("fpu_state", rd, (ev != 8'h00) ? fv : 32'h0);
	endtask : do_op

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		logic [31:0] exp_rst [5];
		exp_rst = '{MQS_CTRL_RST, {13'h0, MQS_TAG_RST, MQS_TOP_RST}, 32'h0, 32'h0, 32'h0};
		void'($urandom(46));
		repeat (8) @(posedge clk);
		srst <= 1'h0;
		@(posedge clk);
		// Reset values, unmapped address last
		for (int i = 0; i < 5; i++) begin
			reg_r(8'(4 * i), rd);
			chk("reg_reset", rd, exp_rst[i]);
		end
		reg_w(8'h10, 32'hffff_ffff);
		reg_r(8'h10, rd);
		chk("unmapped", rd, 32'h0);
		reg_w(MQS_OFF_CTRL, 32'h0000_0aa4);
		reg_r(MQS_OFF_CTRL, rd);
		chk("ctrl_rw", rd, 32'h0000_0aa4);
		repeat (300) do_op();
		reg_r(MQS_OFF_COUNT, rd);
		chk("store_count", rd, 32'(n_st));
		reg_r(MQS_OFF_FAULT, rd);
		chk("flog", rd, {24'h0, lastv});
		reg_w(MQS_OFF_FAULT, 32'h0);
		reg_w(MQS_OFF_COUNT, 32'h0);
		reg_r(MQS_OFF_FAULT, rd);
		chk("flog_clr", rd, 32'h0);
		reg_r(MQS_OFF_COUNT, rd);
		chk("cnt_clr", rd, 32'h0);
		test_done();
	end
endmodule : byte_masked_quadword_store_tb_top
